// ===== rtl/rsl_map.svh
// Register map, field positions, reset values and timing for the signal strength unit
// Function
// - Estimate is built only from samples taken after the channel filter.
// - Each of four fast readout registers can be set to show the latched value.
// - Fast readout reads finish within 16 serial clocks, no ready wait.
// - Latched value is captured only once per packet, at a chosen point.
// - Status query returns both the current and the latched value.
// - Query answer becomes ready 33 us after the query is issued.
// - Latch trigger: preamble, sync, or bit count after RX start, at least 4.
// - Estimate updates every bit, or averaged and updated every four bits.
// - With averaging, the earliest latch point is 7 bit times after RX start; the code latches at the next four-bit update, bit 8.
// - RX entry clears latched values; they stay held afterwards.
// - Latched value read before a new capture returns zero.
// - Jump above a programmed amount during a packet raises an event.
// - A jump may automatically reset the modem or the receiver.
// - Jump detection is off after reset until software enables it.
// - Seven-bit offset in 1 dB steps; 7'h32 means no offset.
// - Estimate above the clear-channel threshold can notify the host.
// - Latched and non-latched threshold indications selectable on any output pin.
// - Reported value has half a decibel per step.
`ifndef RSL_MAP_SVH
`define RSL_MAP_SVH
`define RSL_A_LATCH_CFG 8'h00
`define RSL_A_JUMP_CFG 8'h04
`define RSL_A_JUMP_AMT 8'h08
`define RSL_A_OFFSET 8'h0C
`define RSL_A_THRESH 8'h10
`define RSL_A_FRR_SEL 8'h14
`define RSL_A_FRR0 8'h18
`define RSL_A_QUERY 8'h28
`define RSL_A_RESP 8'h2C
`define RSL_A_INT_STAT 8'h30
`define RSL_A_INT_MASK 8'h34
`define RSL_A_GPIO_SEL 8'h38
`define RSL_OFFSET_ZERO 7'h32
`define RSL_MIN_BITS 8'h04
`define RSL_MIN_BITS_AVG 8'h07
`define RSL_CNT_RST 8'h0A
`define RSL_AVG_LEN 2'h3
`define RSL_INT_THR 0
`define RSL_INT_JUMP 1
`define RSL_INT_LATCH 2
`define RSL_INT_QUERY 3
`define RSL_PCLK_NS 100
`define RSL_QUERY_NS 33000
`define RSL_QUERY_CYC ((`RSL_QUERY_NS + `RSL_PCLK_NS - 1) / `RSL_PCLK_NS)
`endif

// ===== rtl/rsl_pkg.sv
// Types shared by the signal strength unit
package rsl_pkg;
  typedef enum logic [1:0] {
    RSL_TRIG_PREAMBLE = 2'h0,
    RSL_TRIG_SYNC = 2'h1,
    RSL_TRIG_COUNT = 2'h2,
    RSL_TRIG_RSVD = 2'h3
  } rsl_trig_type;
  typedef enum logic [1:0] {
    RSL_FRR_OFF = 2'h0,
    RSL_FRR_LATCHED = 2'h1,
    RSL_FRR_CURRENT = 2'h2,
    RSL_FRR_INT = 2'h3
  } rsl_frr_type;
  typedef enum logic [1:0] {
    RSL_Q_IDLE = 2'b01,
    RSL_Q_BUSY = 2'b10
  } rsl_query_type;
endpackage : rsl_pkg

// ===== rtl/rsl_top.sv
// Signal strength estimate, per-packet latch, threshold and jump detection with APB registers
`timescale 1ns/10ps
`include "rsl_map.svh"
module rsl_top
  import rsl_pkg::*;
#(
  parameter int NUM_GPIO = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clk,
  input wire logic [7:0] filt_power,
  input wire logic rx_enter,
  input wire logic pkt_active,
  input wire logic preamble_det,
  input wire logic sync_det,
  output logic irq,
  output logic [NUM_GPIO-1:0] gpio_out,
  output logic modem_reset,
  output logic rx_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [1:0] trig_sel_r;
  logic avg_en_r;
  logic [7:0] bit_cnt_cfg_r;
  logic [2:0] jump_cfg_r;
  logic [7:0] jump_amt_r;
  logic [6:0] offset_r;
  logic [7:0] thresh_r;
  logic [7:0] frr_sel_r;
  logic [3:0] int_stat_r;
  logic [3:0] int_mask_r;
  logic [2*NUM_GPIO-1:0] gpio_sel_r;

  wire bus_wr = psel && penable && pwrite;

  // Zero wait states keep every fast readout far inside 16 serial clocks
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock synchroniser, edge from agreeing second and third stages
  logic bsync1_r;
  logic bsync2_r;
  logic bsync3_r;
  logic blevel_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsync1_r <= 1'b0;
      bsync2_r <= 1'b0;
      bsync3_r <= 1'b0;
      blevel_r <= 1'b0;
    end else begin
      bsync1_r <= bit_clk;
      bsync2_r <= bsync1_r;
      bsync3_r <= bsync2_r;
      if (bsync2_r == bsync3_r) begin
        blevel_r <= bsync3_r;
      end
    end
  end

  wire bit_tick = (bsync2_r == bsync3_r) && bsync3_r && !blevel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Estimate: per bit or four-bit average of post-filter power
  logic [9:0] acc_r;
  logic [1:0] avg_cnt_r;
  logic [7:0] est_r;
  logic est_upd_r;

  wire [9:0] acc_sum = acc_r + {2'b00, filt_power};
  wire avg_last = (avg_cnt_r == `RSL_AVG_LEN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= 10'h000;
      avg_cnt_r <= 2'h0;
      est_r <= 8'h00;
      est_upd_r <= 1'b0;
    end else begin
      est_upd_r <= 1'b0;
      if (rx_enter) begin
        acc_r <= 10'h000;
        avg_cnt_r <= 2'h0;
      end else if (bit_tick) begin
        if (!avg_en_r) begin
          est_r <= filt_power;
          est_upd_r <= 1'b1;
        end else if (avg_last) begin
          est_r <= acc_sum[9:2];
          est_upd_r <= 1'b1;
          acc_r <= 10'h000;
          avg_cnt_r <= 2'h0;
        end else begin
          acc_r <= acc_sum;
          avg_cnt_r <= avg_cnt_r + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset in 1 dB steps, i.e. two half-dB units, saturated to 8 bits
  wire signed [10:0] off_delta = $signed({4'h0, offset_r}) - $signed({4'h0, `RSL_OFFSET_ZERO});
  wire signed [10:0] rep_full = $signed({3'b000, est_r}) + (off_delta <<< 1);
  wire [7:0] reported = rep_full[10] ? 8'h00 : (|rep_full[9:8] ? 8'hFF : rep_full[7:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Per-packet latch
  logic [7:0] bits_r;
  logic trig_seen_r;
  logic latched_done_r;
  logic [7:0] latched_r;

  wire [7:0] min_bits = avg_en_r ? `RSL_MIN_BITS_AVG : `RSL_MIN_BITS;
  wire [7:0] cnt_need = (bit_cnt_cfg_r > min_bits) ? bit_cnt_cfg_r : min_bits;
  wire trig_now = (trig_sel_r == RSL_TRIG_PREAMBLE && preamble_det) ||
                  (trig_sel_r == RSL_TRIG_SYNC && sync_det) ||
                  (trig_sel_r == RSL_TRIG_COUNT && bits_r >= cnt_need);
  wire trig_any = trig_now || trig_seen_r;
  // Averaged estimate needs a fresh update so a stale value is never captured
  wire est_ready = avg_en_r ? est_upd_r : 1'b1;
  wire do_latch = !latched_done_r && trig_any && (bits_r >= min_bits) && est_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_r <= 8'h00;
      trig_seen_r <= 1'b0;
      latched_done_r <= 1'b0;
      latched_r <= 8'h00;
    end else if (rx_enter) begin
      bits_r <= 8'h00;
      trig_seen_r <= 1'b0;
      latched_done_r <= 1'b0;
      latched_r <= 8'h00;
    end else begin
      if (bit_tick && bits_r != 8'hFF) begin
        bits_r <= bits_r + 8'h01;
      end
      if (trig_now && !latched_done_r) begin
        trig_seen_r <= 1'b1;
      end
      if (do_latch) begin
        latched_r <= reported;
        latched_done_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear-channel threshold, live and sticky versions; a live hit beats the RX-entry clear
  wire thr_live = reported > thresh_r;
  logic thr_hold_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_hold_r <= 1'b0;
    end else if (thr_live) begin
      thr_hold_r <= 1'b1;
    end else if (rx_enter) begin
      thr_hold_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jump detection against the level at packet start
  logic pkt_d_r;
  logic [7:0] ref_r;
  logic jump_r;

  wire pkt_start = pkt_active && !pkt_d_r;
  wire [7:0] diff = (reported > ref_r) ? (reported - ref_r) : (ref_r - reported);
  wire jump_hit = jump_cfg_r[0] && pkt_active && !pkt_start &&
                  est_upd_r && (diff > jump_amt_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_d_r <= 1'b0;
      ref_r <= 8'h00;
      jump_r <= 1'b0;
      modem_reset <= 1'b0;
      rx_reset <= 1'b0;
    end else begin
      pkt_d_r <= pkt_active;
      if (pkt_start) begin
        ref_r <= reported;
      end
      jump_r <= jump_hit;
      modem_reset <= jump_hit && jump_cfg_r[1];
      rx_reset <= jump_hit && jump_cfg_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status query with delayed ready
  localparam int QCYC = `RSL_QUERY_CYC;
  rsl_query_type q_state_r;
  logic [15:0] q_cnt_r;
  logic [7:0] resp_cur_r;
  logic [7:0] resp_lat_r;
  logic q_done;

  wire q_start = bus_wr && paddr == `RSL_A_QUERY;
  assign q_done = (q_state_r == RSL_Q_BUSY) && (q_cnt_r == 16'(QCYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_state_r <= RSL_Q_IDLE;
      q_cnt_r <= 16'h0000;
      resp_cur_r <= 8'h00;
      resp_lat_r <= 8'h00;
    end else begin
      unique case (q_state_r)
        RSL_Q_IDLE: begin
          if (q_start) begin
            q_state_r <= RSL_Q_BUSY;
            q_cnt_r <= 16'h0000;
            resp_cur_r <= reported;
            resp_lat_r <= latched_r;
          end
        end
        RSL_Q_BUSY: begin
          q_cnt_r <= q_cnt_r + 16'h0001;
          if (q_done) begin
            q_state_r <= RSL_Q_IDLE;
          end
        end
      endcase
    end
  end

  wire cts = (q_state_r == RSL_Q_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set beats clear
  wire [3:0] int_set = {q_done, do_latch, jump_r, thr_live && est_upd_r};
  wire [3:0] int_clr = (bus_wr && paddr == `RSL_A_INT_STAT) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= 4'h0;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_set;
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Output pin selection
  genvar g;
  generate
    for (g = 0; g < NUM_GPIO; g++) begin : g_gpio
      wire [1:0] sel = gpio_sel_r[2*g +: 2];
      assign gpio_out[g] = (sel == 2'h0) ? thr_live :
                           (sel == 2'h1) ? thr_hold_r :
                           (sel == 2'h2) ? int_stat_r[`RSL_INT_JUMP] : irq;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sel_r <= 2'h0;
      avg_en_r <= 1'b0;
      bit_cnt_cfg_r <= `RSL_CNT_RST;
      jump_cfg_r <= 3'h0;
      jump_amt_r <= 8'h00;
      offset_r <= `RSL_OFFSET_ZERO;
      thresh_r <= 8'hFF;
      frr_sel_r <= 8'h00;
      int_mask_r <= 4'h0;
      gpio_sel_r <= '0;
    end else if (bus_wr) begin
      unique case (paddr)
        `RSL_A_LATCH_CFG: begin
          trig_sel_r <= pwdata[1:0];
          avg_en_r <= pwdata[2];
          bit_cnt_cfg_r <= pwdata[15:8];
        end
        `RSL_A_JUMP_CFG: jump_cfg_r <= pwdata[2:0];
        `RSL_A_JUMP_AMT: jump_amt_r <= pwdata[7:0];
        `RSL_A_OFFSET: offset_r <= pwdata[6:0];
        `RSL_A_THRESH: thresh_r <= pwdata[7:0];
        `RSL_A_FRR_SEL: frr_sel_r <= pwdata[7:0];
        `RSL_A_INT_MASK: int_mask_r <= pwdata[3:0];
        `RSL_A_GPIO_SEL: gpio_sel_r <= pwdata[2*NUM_GPIO-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  function automatic logic [7:0] frr_val(input logic [1:0] sel, input logic [7:0] lat,
                                         input logic [7:0] cur, input logic [3:0] st);
    frr_val = (sel == RSL_FRR_LATCHED) ? lat :
              (sel == RSL_FRR_CURRENT) ? cur :
              (sel == RSL_FRR_INT) ? {4'h0, st} : 8'h00;
  endfunction : frr_val

  wire is_frr = (paddr >= `RSL_A_FRR0) && (paddr < `RSL_A_QUERY) && (paddr[1:0] == 2'b00);
  wire [1:0] frr_idx = 2'(paddr - `RSL_A_FRR0 >> 2);
  wire [7:0] frr_rd = frr_val(frr_sel_r[2*frr_idx +: 2], latched_r, reported, int_stat_r);
  wire mapped = is_frr || paddr == `RSL_A_LATCH_CFG || paddr == `RSL_A_JUMP_CFG ||
                paddr == `RSL_A_JUMP_AMT || paddr == `RSL_A_OFFSET || paddr == `RSL_A_THRESH ||
                paddr == `RSL_A_FRR_SEL || paddr == `RSL_A_QUERY || paddr == `RSL_A_RESP ||
                paddr == `RSL_A_INT_STAT || paddr == `RSL_A_INT_MASK || paddr == `RSL_A_GPIO_SEL;
  wire frr_ro_wr = is_frr && pwrite;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_frr) begin
      rd_mux = {24'h00_0000, frr_rd};
    end else begin
      unique case (paddr)
        `RSL_A_LATCH_CFG: rd_mux = {16'h0000, bit_cnt_cfg_r, 5'h00, avg_en_r, trig_sel_r};
        `RSL_A_JUMP_CFG: rd_mux = {29'h0000_0000, jump_cfg_r};
        `RSL_A_JUMP_AMT: rd_mux = {24'h00_0000, jump_amt_r};
        `RSL_A_OFFSET: rd_mux = {25'h000_0000, offset_r};
        `RSL_A_THRESH: rd_mux = {24'h00_0000, thresh_r};
        `RSL_A_FRR_SEL: rd_mux = {24'h00_0000, frr_sel_r};
        `RSL_A_QUERY: rd_mux = {31'h0000_0000, cts};
        `RSL_A_RESP: rd_mux = {16'h0000, resp_lat_r, resp_cur_r};
        `RSL_A_INT_STAT: rd_mux = {28'h000_0000, int_stat_r};
        `RSL_A_INT_MASK: rd_mux = {28'h000_0000, int_mask_r};
        `RSL_A_GPIO_SEL: rd_mux = {{(32-2*NUM_GPIO){1'b0}}, gpio_sel_r};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data registered during setup so it is stable at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pslverr = psel && penable && (!mapped || frr_ro_wr);

endmodule : rsl_top

// ===== testbench/rsl_top_asserts.sv
// Port-level checks for the signal strength unit
`timescale 1ns/10ps
`include "rsl_map.svh"
module rsl_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pkt_active,
  input wire logic modem_reset,
  input wire logic rx_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc_w;
  logic en_seen_r;
  logic [8:0] q_cnt_r;
  assign acc_w = psel && penable && pready;
  // Shadow of the query wait, reloaded only once idle, as the block does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen_r <= 1'b0;
      q_cnt_r <= 9'h000;
    end else begin
      if (acc_w && pwrite && paddr == `RSL_A_JUMP_CFG && pwdata[0]) en_seen_r <= 1'b1;
      if (acc_w && pwrite && paddr == `RSL_A_QUERY && q_cnt_r == 9'h000) q_cnt_r <= 9'(`RSL_QUERY_CYC);
      else if (q_cnt_r != 9'h000) q_cnt_r <= q_cnt_r - 9'h001;
    end
  end
  ready_a: assert property (psel && penable |-> pready)
    else $error("no ready in access");
  frr_ro_a: assert property (acc_w && pwrite && paddr >= 8'h18 && paddr <= 8'h24 |-> pslverr)
    else $error("readout write accepted");
  unmapped_err_a: assert property (acc_w && paddr == 8'h3C |-> pslverr)
    else $error("unmapped access accepted");
  mreset_pulse_a: assert property ($rose(modem_reset) |=> !modem_reset)
    else $error("modem reset too long");
  rreset_pulse_a: assert property (rx_reset |=> !rx_reset)
    else $error("rx reset too long");
  jump_gate_a: assert property (modem_reset || rx_reset |-> en_seen_r)
    else $error("jump reset while disabled");
  jump_pkt_a: assert property (modem_reset || rx_reset |-> pkt_active || $past(pkt_active) ||
    $past(pkt_active, 2) || $past(pkt_active, 3))
    else $error("jump outside packet");
  query_busy_a: assert property (acc_w && !pwrite && paddr == `RSL_A_QUERY && q_cnt_r > 9'h003 &&
    q_cnt_r < 9'h14A |-> !prdata[0])
    else $error("query ready too early");
  query_idle_a: assert property (acc_w && !pwrite && paddr == `RSL_A_QUERY && q_cnt_r == 9'h000 &&
    $past(q_cnt_r) == 9'h000 |-> prdata[0])
    else $error("query ready too late");
endmodule : rsl_top_asserts

// ===== testbench/rsl_feed.sv
// Modem-side feed: bit clock, filtered power samples and packet events
`timescale 1ns/10ps
module rsl_feed (
  input wire logic pclk,
  output logic bit_clk,
  output logic [7:0] filt_power,
  output logic rx_enter,
  output logic pkt_active,
  output logic preamble_det,
  output logic sync_det
);
  initial begin
    bit_clk = 1'b0;
    filt_power = 8'h00;
    rx_enter = 1'b0;
    pkt_active = 1'b0;
    preamble_det = 1'b0;
    sync_det = 1'b0;
  end
  // Bit clock runs only while a test calls bits, kept off the bus clock edges
  task automatic bits(input int n);
    #37;
    repeat (n) begin
      #400 bit_clk = 1'b1;
      #400 bit_clk = 1'b0;
    end
  endtask : bits
  task automatic power(input logic [7:0] p);
    @(posedge pclk);
    filt_power <= p;
  endtask : power
  task automatic enter();
    @(posedge pclk);
    rx_enter <= 1'b1;
    @(posedge pclk);
    rx_enter <= 1'b0;
    // Let the clearing edge settle before anyone looks at the outputs
    #1;
  endtask : enter
  task automatic pkt(input logic a);
    @(posedge pclk);
    pkt_active <= a;
  endtask : pkt
  task automatic det(input logic a, input logic b);
    @(posedge pclk);
    preamble_det <= a;
    sync_det <= b;
  endtask : det
endmodule : rsl_feed

// ===== testbench/rsl_top_tb.sv
// Self-checking bench for the signal strength unit
`timescale 1ns/10ps
`include "rsl_map.svh"
module rsl_top_tb
  import rsl_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, irq, modem_reset, rx_reset, bit_clk, rx_enter, pkt_active, preamble_det, sync_det;
  logic [1:0] gpio_out;
  logic [7:0] filt_power, pw;
  logic [32:0] exp_q[$], msk_q[$];
  logic [32:0] all_m = 33'h1_FFFF_FFFF;
  logic [6:0] offs[4] = '{7'h3A, 7'h2A, 7'h7F, 7'h00};
  int fails = 0;
  int tests_run = 0;
  int mr_n = 0;
  int rr_n = 0;
  initial begin
    forever #50 pclk = ~pclk;
  end
  rsl_top #(.NUM_GPIO(2)) i_rsl_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bit_clk, .filt_power, .rx_enter, .pkt_active, .preamble_det, .sync_det, .irq,
    .gpio_out, .modem_reset, .rx_reset);
  rsl_feed i_rsl_feed (.pclk, .bit_clk, .filt_power, .rx_enter, .pkt_active, .preamble_det, .sync_det);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [32:0] got, input logic [32:0] e, input logic [32:0] m);
    tests_run++;
    if (((got ^ e) & m) !== 33'h0_0000_0000) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, e);
    end
  endtask : cmp
  task automatic pin(input logic g, input logic e);
    cmp({32'h0000_0000, g}, {32'h0000_0000, e}, 33'h0_0000_0001);
  endtask : pin
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    if (n >= 50) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic run(input int n);
    i_rsl_feed.bits(n);
    repeat (6) @(posedge pclk);
    #1;
  endtask : run
  function automatic logic [7:0] rep(input logic [7:0] p, input logic [6:0] c);
    int v;
    v = int'(p) + 2 * (int'(c) - 50);
    return (v > 255) ? 8'hFF : (v < 0) ? 8'h00 : 8'(v);
  endfunction : rep
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (modem_reset === 1'b1) mr_n++;
    if (rx_reset === 1'b1) rr_n++;
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      cmp({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
    end
  end
  initial begin
    #2000000;
    fails++;
    conclude();
  end
  initial begin
    rv = $urandom(49);
    pw = 8'($urandom_range(140, 110));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RSL_A_LATCH_CFG, 33'h0_0000_0A00, all_m);
    rd(`RSL_A_JUMP_CFG, 33'h0_0000_0000, all_m);
    rd(`RSL_A_OFFSET, 33'h0_0000_0032, all_m);
    rd(8'h3C, 33'h1_0000_0000, 33'h1_0000_0000);
    wr(`RSL_A_FRR0, 32'h0000_0001);
    wr(`RSL_A_FRR_SEL, 32'({RSL_FRR_INT, RSL_FRR_LATCHED, RSL_FRR_CURRENT, RSL_FRR_LATCHED}));
    for (int t = 0; t < 3; t++) begin
      wr(`RSL_A_LATCH_CFG, {16'h0000, 8'h02, 6'h00, 2'(t)});
      i_rsl_feed.power(pw);
      i_rsl_feed.enter();
      rd(`RSL_A_FRR0, 33'h0_0000_0000, all_m);
      run(3);
      rd(`RSL_A_FRR0 + 8'h08, 33'h0_0000_0000, all_m);
      i_rsl_feed.det(t == 0, t == 1);
      run(3);
      rd(`RSL_A_FRR0 + 8'h08, {25'h0, pw}, all_m);
      i_rsl_feed.det(1'b0, 1'b0);
      i_rsl_feed.power(pw ^ 8'h40);
      run(4);
      rd(`RSL_A_FRR0, {25'h0, pw}, all_m);
      rd(`RSL_A_FRR0 + 8'h04, {25'h0, pw ^ 8'h40}, all_m);
    end
    wr(`RSL_A_LATCH_CFG, 32'h0000_0406);
    i_rsl_feed.power(pw);
    i_rsl_feed.enter();
    run(6);
    rd(`RSL_A_FRR0, 33'h0_0000_0000, all_m);
    run(6);
    rd(`RSL_A_FRR0, {25'h0, pw}, all_m);
    i_rsl_feed.power(pw ^ 8'h40);
    run(1);
    rd(`RSL_A_FRR0 + 8'h04, {25'h0, pw}, all_m);
    run(3);
    foreach (offs[i]) begin
      wr(`RSL_A_OFFSET, {25'h0, offs[i]});
      rd(`RSL_A_FRR0 + 8'h04, {25'h0, rep(pw ^ 8'h40, offs[i])}, all_m);
    end
    wr(`RSL_A_OFFSET, 32'h0000_0032);
    wr(`RSL_A_INT_STAT, 32'h0000_000F);
    wr(`RSL_A_QUERY, 32'h0000_0001);
    rd(`RSL_A_QUERY, 33'h0_0000_0000, 33'h0_0000_0001);
    rv = 32'h0000_0000;
    for (int k = 0; k < 150 && rv[0] !== 1'b1; k++) apb(1'b0, `RSL_A_QUERY, 32'h0000_0000);
    pin(rv[0], 1'b1);
    rd(`RSL_A_RESP, {17'h0, pw, pw ^ 8'h40}, 33'h0_0000_FFFF);
    pin(irq, 1'b0);
    wr(`RSL_A_INT_MASK, 32'h0000_0008);
    pin(irq, 1'b1);
    wr(`RSL_A_INT_STAT, 32'h0000_0008);
    pin(irq, 1'b0);
    wr(`RSL_A_GPIO_SEL, 32'h0000_0004);
    wr(`RSL_A_THRESH, {24'h0, (pw ^ 8'h40) - 8'h01});
    pin(gpio_out[0], 1'b1);
    wr(`RSL_A_THRESH, {24'h0, pw ^ 8'h40});
    pin(gpio_out[0], 1'b0);
    pin(gpio_out[1], 1'b1);
    i_rsl_feed.enter();
    pin(gpio_out[1], 1'b0);
    wr(`RSL_A_LATCH_CFG, 32'h0000_0402);
    wr(`RSL_A_JUMP_AMT, 32'h0000_000A);
    i_rsl_feed.power(pw);
    run(2);
    i_rsl_feed.pkt(1'b1);
    i_rsl_feed.power(pw + 8'h1E);
    run(2);
    rd(`RSL_A_INT_STAT, 33'h0_0000_0000, 33'h0_0000_0002);
    i_rsl_feed.pkt(1'b0);
    wr(`RSL_A_JUMP_CFG, 32'h0000_0007);
    run(2);
    rd(`RSL_A_INT_STAT, 33'h0_0000_0000, 33'h0_0000_0002);
    i_rsl_feed.power(pw);
    run(2);
    i_rsl_feed.pkt(1'b1);
    i_rsl_feed.power(pw + 8'h1E);
    run(2);
    rd(`RSL_A_INT_STAT, 33'h0_0000_0002, 33'h0_0000_0002);
    pin(mr_n != 0 && rr_n != 0, 1'b1);
    rd(`RSL_A_FRR0 + 8'h0C, 33'h0_0000_0002, 33'h0_0000_0002);
    wr(`RSL_A_GPIO_SEL, 32'h0000_000E);
    wr(`RSL_A_INT_MASK, 32'h0000_0002);
    pin(gpio_out[0], 1'b1);
    pin(gpio_out[1], 1'b1);
    pin(irq, 1'b1);
    i_rsl_feed.pkt(1'b0);
    conclude();
  end
endmodule : rsl_top_tb
bind rsl_top rsl_top_asserts i_rsl_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pkt_active(pkt_active), .modem_reset(modem_reset), .rx_reset(rx_reset));
